// >>> verilog/gtc_regs.svh
// register offsets, field positions, reset values and timing counts of the gated timer
`ifndef GTC_REGS_SVH
`define GTC_REGS_SVH
`define GTC_OFF_CTRL     12'h000
`define GTC_OFF_GATE     12'h004
`define GTC_OFF_COUNT    12'h008
`define GTC_OFF_OSC      12'h00C
`define GTC_OFF_FLAG     12'h010
`define GTC_OFF_IEN      12'h014
`define GTC_CTRL_ON      0
`define GTC_CTRL_CS_LO   1
`define GTC_CTRL_CS_HI   2
`define GTC_CTRL_OSCSEL  3
`define GTC_GATE_GSS_LO  0
`define GTC_GATE_GSS_HI  1
`define GTC_GATE_GVAL    2
`define GTC_GATE_GO      3
`define GTC_GATE_SPM     4
`define GTC_GATE_GTM     5
`define GTC_GATE_POL     6
`define GTC_GATE_GE      7
`define GTC_OSC_WARMUP   0
`define GTC_OSC_CALCFG   1
`define GTC_OSC_SCS_LO   2
`define GTC_OSC_SCS_HI   3
`define GTC_CS_INSTR     2'h0
`define GTC_CS_SYSTEM    2'h1
`define GTC_CS_EXTERNAL  2'h2
`define GTC_SCS_SECONDARY_OSCILLATOR     2'h1
`define GTC_COUNT_RESET  16'h0000
`define GTC_COUNT_MAX    16'hFFFF
`define GTC_CLK_PERIOD_NS 5
`define GTC_INSTR_NS     20
`define GTC_INSTR_CYCLES (`GTC_INSTR_NS / `GTC_CLK_PERIOD_NS)
`endif

// >>> verilog/gtc_pkg.sv
// types shared by the gated timer
package gtc_pkg;
  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic       toggleEn;
    logic       singlePulseEn;
    logic [1:0] sourceSel;
  } gtc_gate_cfg_t;
  typedef struct packed {
    logic       timerOn;
    logic [1:0] clockSourceSel;
    logic       oscSelect;
  } gtc_timer_cfg_t;
  typedef enum logic [1:0] {
    GTC_SP_IDLE,
    GTC_SP_ARMED,
    GTC_SP_ACTIVE
  } gtc_sp_state_t;
  typedef enum logic [1:0] {
    GTC_SRC_PIN,
    GTC_SRC_MATCH,
    GTC_SRC_CMP1,
    GTC_SRC_CMP2
  } gtc_gate_src_t;
endpackage

// >>> verilog/gtc_timer.sv
// gated 16-bit timer/counter with apb register access
// What this block does
// RL1: secondary oscillator runs when any requester asks for it.
// RL2: oscillator counts only with external clock source selected, on rising edges.
// RL3: gate enable places counting under gate control, else free count.
// RL4: gate active increments on selected clock edge; inactive holds count.
// RL5: polarity 0 counts on low gate, polarity 1 on high gate.
// RL6: two-bit select picks pin, match pulse, comparator one, comparator two.
// RL7: companion timer rollover makes one instruction cycle high gate pulse.
// RL8: match source gates one cycle per match, or all but that cycle.
// RL9: comparator source gates from that comparator's output transitions.
// RL10: toggle mode routes gate through flip-flop toggling on incrementing edges.
// RL11: toggle flip-flop forced and held clear while toggle mode off.
// RL12: in toggle mode level status shows toggled gate counting.
// RL13: software sets single-pulse enable first, then go/done.
// RL14: armed timer enables on next incrementing edge; go clears on trailing edge.
// RL15: after completion no gate event counts until go set again.
// RL16: clearing single-pulse enable also clears go/done.
// RL17: toggle plus single pulse measures exactly one full gate cycle.
// RL18: read-only gate level status reflects gate level even ungated.
// RL19: falling level status sets gate-event flag; enable raises request.
// RL20: count wraps FFFFh to 0000h and each wrap latches overflow flag.
// RL21: overflow flag bit position follows timer instance, enable gates request.
// RL22: overflow enable bit position follows timer instance.
// RL23: gate enable only takes effect while timer is on.
// RL24: flags sticky until cleared; asynchronous gate sources synchronised first.
`timescale 1ns/1ps
`include "gtc_regs.svh"
module gtc_timer #(
  parameter int TIMER_ID   = 3,
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   secondaryOscClk,
  input  wire logic                   extClkPin,
  input  wire logic                   gatePin,
  input  wire logic                   companionRollover,
  input  wire logic                   comparatorOneOut,
  input  wire logic                   comparatorTwoOut,
  output logic                        secondaryOscRun,
  output logic                        overflowIrq,
  output logic                        gateEventIrq
);
  import gtc_pkg::*;

  localparam int OVF_BIT  = (TIMER_ID == 7) ? 3 : 1;
  localparam int GEV_BIT  = (TIMER_ID == 3) ? 0 : 7;
  localparam int INSTR_CY = (`GTC_INSTR_CYCLES < 1) ? 1 : `GTC_INSTR_CYCLES;

  // only three instances exist and the map needs five address bits
  if (TIMER_ID != 3 && TIMER_ID != 5 && TIMER_ID != 7) begin : g_bad_id
    $error("TIMER_ID must be 3, 5 or 7");
  end
  if (ADDR_WIDTH < 5) begin : g_bad_addr
    $error("ADDR_WIDTH too small for register map");
  end

  // configuration registers
  gtc_timer_cfg_t tcfg_q;
  gtc_gate_cfg_t  gcfg_q;
  logic           goDone_q;
  logic           warmup_q;
  logic           calCfg_q;
  logic [1:0]     cpuClkSel_q;
  logic [15:0]    count_q;
  logic           ovfFlag_q;
  logic           gevFlag_q;
  logic           ovfIen_q;
  logic           gevIen_q;

  // synchronisers: stage one is read only by stage two
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic [1:0] clkEdge_q;
  logic [1:0] cmpSyncA_q;
  logic [1:0] cmpSyncB_q;
  wire  logic secondary_oscillator  = syncB_q[0];
  wire  logic sExt  = syncB_q[1];
  wire  logic sPin  = syncB_q[2];
  wire  logic sCmp1 = cmpSyncB_q[0];

  // RL24 sync async sources
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
      cmpSyncA_q <= 2'h0;
      cmpSyncB_q <= 2'h0;
    end else begin
      syncA_q <= {gatePin, extClkPin, secondaryOscClk};
      syncB_q <= syncA_q;
      cmpSyncA_q <= {comparatorTwoOut, comparatorOneOut};
      cmpSyncB_q <= cmpSyncA_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      clkEdge_q <= 2'h0;
    else
      clkEdge_q <= {sExt, secondary_oscillator};
  end

  // instruction-cycle tick
  logic [7:0] instrDiv_q;
  wire  logic instrTick = (instrDiv_q == 8'(INSTR_CY - 1));
  always_ff @(posedge clk) begin
    if (reset)
      instrDiv_q <= 8'h00;
    else if (instrTick)
      instrDiv_q <= 8'h00;
    else
      instrDiv_q <= instrDiv_q + 8'h01;
  end

  // RL2 external source uses oscillator only when selected
  wire logic oscRise = secondary_oscillator & ~clkEdge_q[0];
  wire logic extRise = sExt & ~clkEdge_q[1];
  wire logic extTick = tcfg_q.oscSelect ? oscRise : extRise;
  wire logic clkTick = (tcfg_q.clockSourceSel == `GTC_CS_INSTR)  ? instrTick :
                       (tcfg_q.clockSourceSel == `GTC_CS_SYSTEM) ? 1'b1 :
                       (tcfg_q.clockSourceSel == `GTC_CS_EXTERNAL) ? extTick : 1'b0;

  // RL7 stretch companion rollover to one instruction cycle
  logic [7:0] matchCnt_q;
  logic       matchPulse_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      matchCnt_q <= 8'h00;
      matchPulse_q <= 1'b0;
    end else if (companionRollover) begin
      matchCnt_q <= 8'(INSTR_CY - 1);
      matchPulse_q <= 1'b1;
    end else if (matchCnt_q != 8'h00) begin
      matchCnt_q <= matchCnt_q - 8'h01;
    end else begin
      matchPulse_q <= 1'b0;
    end
  end

  // RL6 gate source select
  // RL9 comparator levels follow their transitions
  wire logic gateRaw = (gcfg_q.sourceSel == GTC_SRC_PIN)   ? sPin :
                       (gcfg_q.sourceSel == GTC_SRC_MATCH) ? matchPulse_q :
                       (gcfg_q.sourceSel == GTC_SRC_CMP1)  ? sCmp1 : cmpSyncB_q[1];
  // RL5 polarity
  // RL8 polarity 0 inverts the match pulse
  wire logic gatePol = gcfg_q.polarity ? gateRaw : ~gateRaw;

  // RL10 toggle flip-flop on incrementing edges
  logic gatePolD_q;
  logic toggle_q;
  wire  logic polRise = gatePol & ~gatePolD_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      gatePolD_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      gatePolD_q <= gatePol;
      // RL11 held clear outside toggle mode
      if (!gcfg_q.toggleEn)
        toggle_q <= 1'b0;
      else if (polRise)
        toggle_q <= ~toggle_q;
    end
  end
  wire logic gateTgl = gcfg_q.toggleEn ? toggle_q : gatePol;

  // single pulse sequencer
  gtc_sp_state_t spState_q;
  logic          gateTglD_q;
  wire  logic    tglRise = gateTgl & ~gateTglD_q;
  wire  logic    tglFall = ~gateTgl & gateTglD_q;
  wire  logic    spDone  = (spState_q == GTC_SP_ACTIVE) & tglFall;
  // RL15 blocked unless in active pulse
  wire  logic    gateFinal = gcfg_q.singlePulseEn ?
                             (spState_q == GTC_SP_ACTIVE) & gateTgl : gateTgl;

  // RL14 arm, enable on edge, finish on trailing edge
  // RL17 toggle feeds one full cycle as one pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      spState_q <= GTC_SP_IDLE;
      gateTglD_q <= 1'b0;
    end else begin
      gateTglD_q <= gateTgl;
      case (spState_q)
        GTC_SP_IDLE:
          if (goDone_q && gcfg_q.singlePulseEn)
            spState_q <= GTC_SP_ARMED;
        GTC_SP_ARMED:
          if (!goDone_q)
            spState_q <= GTC_SP_IDLE;
          else if (tglRise)
            spState_q <= GTC_SP_ACTIVE;
        GTC_SP_ACTIVE:
          if (tglFall || !goDone_q)
            spState_q <= GTC_SP_IDLE;
        default:
          spState_q <= GTC_SP_IDLE;
      endcase
    end
  end

  // RL18 level status valid with gating off
  // RL12 toggled level shown in toggle mode
  logic gateVal_q;
  always_ff @(posedge clk) begin
    if (reset)
      gateVal_q <= 1'b0;
    else
      gateVal_q <= gateFinal;
  end
  wire logic gateFallEvt = gateVal_q & ~gateFinal;

  // RL3 gate control under enable
  // RL23 ignored while timer off
  // RL4 count on tick while active
  wire logic countEn = tcfg_q.timerOn & (~gcfg_q.enable | gateFinal);
  wire logic countInc = countEn & clkTick;
  wire logic wrapEvt = countInc & (count_q == `GTC_COUNT_MAX);

  // apb decode
  wire logic [ADDR_WIDTH-1:0] offs = paddr;
  wire logic hitCtrl  = (offs == ADDR_WIDTH'(`GTC_OFF_CTRL));
  wire logic hitGate  = (offs == ADDR_WIDTH'(`GTC_OFF_GATE));
  wire logic hitCount = (offs == ADDR_WIDTH'(`GTC_OFF_COUNT));
  wire logic hitOsc   = (offs == ADDR_WIDTH'(`GTC_OFF_OSC));
  wire logic hitFlag  = (offs == ADDR_WIDTH'(`GTC_OFF_FLAG));
  wire logic hitIen   = (offs == ADDR_WIDTH'(`GTC_OFF_IEN));
  wire logic hitAny   = hitCtrl | hitGate | hitCount | hitOsc | hitFlag | hitIen;
  wire logic access   = psel & penable & ~pready;
  // write lands on the edge that completes the transfer
  wire logic wrEn     = psel & penable & pready & pwrite & hitAny;
  wire logic wrLo     = wrEn & pstrb[0];
  wire logic wrHi     = wrEn & pstrb[1];

  wire logic [31:0] rdCtrl  = {28'h0, tcfg_q.oscSelect, tcfg_q.clockSourceSel, tcfg_q.timerOn};
  wire logic [31:0] rdGate  = {24'h0, gcfg_q.enable, gcfg_q.polarity, gcfg_q.toggleEn,
                               gcfg_q.singlePulseEn, goDone_q, gateVal_q,
                               gcfg_q.sourceSel};
  wire logic [31:0] rdOsc   = {28'h0, cpuClkSel_q, calCfg_q, warmup_q};
  wire logic [31:0] rdFlag  = (32'(ovfFlag_q) << OVF_BIT) | (32'(gevFlag_q) << GEV_BIT);
  wire logic [31:0] rdIen   = (32'(ovfIen_q) << OVF_BIT) | (32'(gevIen_q) << GEV_BIT);
  wire logic [31:0] rdData  = hitCtrl  ? rdCtrl :
                              hitGate  ? rdGate :
                              hitCount ? {16'h0, count_q} :
                              hitOsc   ? rdOsc :
                              hitFlag  ? rdFlag :
                              hitIen   ? rdIen : 32'h0;

  // one wait state, then answer
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access & ~hitAny;
      prdata <= (access & ~pwrite) ? rdData : 32'h0;
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      tcfg_q <= '0;
      gcfg_q <= '0;
      warmup_q <= 1'b0;
      calCfg_q <= 1'b0;
      cpuClkSel_q <= 2'h0;
      ovfIen_q <= 1'b0;
      gevIen_q <= 1'b0;
    end else if (wrLo) begin
      if (hitCtrl)
        tcfg_q <= {pwdata[`GTC_CTRL_ON], pwdata[`GTC_CTRL_CS_HI:`GTC_CTRL_CS_LO],
                   pwdata[`GTC_CTRL_OSCSEL]};
      if (hitGate)
        gcfg_q <= {pwdata[7:4], pwdata[1:0]};
      if (hitOsc) begin
        warmup_q <= pwdata[`GTC_OSC_WARMUP];
        calCfg_q <= pwdata[`GTC_OSC_CALCFG];
        cpuClkSel_q <= pwdata[`GTC_OSC_SCS_HI:`GTC_OSC_SCS_LO];
      end
      if (hitIen) begin
        ovfIen_q <= pwdata[OVF_BIT];
        gevIen_q <= pwdata[GEV_BIT];
      end
    end
  end

  // go/done: software set wins over hardware clear
  // RL16 dropping single-pulse enable clears go
  // RL13 go only arms with single-pulse enabled
  wire logic goWrite  = wrLo & hitGate;
  wire logic goSet    = goWrite & pwdata[`GTC_GATE_GO] & pwdata[`GTC_GATE_SPM];
  wire logic spmOff   = goWrite ? ~pwdata[`GTC_GATE_SPM] : ~gcfg_q.singlePulseEn;
  always_ff @(posedge clk) begin
    if (reset)
      goDone_q <= 1'b0;
    else if (goSet)
      goDone_q <= 1'b1;
    else if (spmOff || spDone || (goWrite && !pwdata[`GTC_GATE_GO]))
      goDone_q <= 1'b0;
  end

  // RL20 count and wrap; software write wins
  always_ff @(posedge clk) begin
    if (reset)
      count_q <= `GTC_COUNT_RESET;
    else if (hitCount && (wrLo || wrHi))
      count_q <= {wrHi ? pwdata[15:8] : count_q[15:8],
                  wrLo ? pwdata[7:0] : count_q[7:0]};
    else if (countInc)
      count_q <= count_q + 16'h0001;
  end

  // RL24 sticky flags, set beats clear
  // RL19 falling level status sets event flag
  // RL21 overflow flag position by instance
  wire logic flagWr = wrEn & hitFlag & pstrb[0];
  always_ff @(posedge clk) begin
    if (reset) begin
      ovfFlag_q <= 1'b0;
      gevFlag_q <= 1'b0;
    end else begin
      if (wrapEvt)
        ovfFlag_q <= 1'b1;
      else if (flagWr && pwdata[OVF_BIT])
        ovfFlag_q <= 1'b0;
      if (gateFallEvt)
        gevFlag_q <= 1'b1;
      else if (flagWr && pwdata[GEV_BIT])
        gevFlag_q <= 1'b0;
    end
  end

  // RL22 enables gate requests
  // RL1 any requester runs the oscillator
  always_ff @(posedge clk) begin
    if (reset) begin
      overflowIrq <= 1'b0;
      gateEventIrq <= 1'b0;
      secondaryOscRun <= 1'b0;
    end else begin
      overflowIrq <= ovfFlag_q & ovfIen_q;
      gateEventIrq <= gevFlag_q & gevIen_q;
      secondaryOscRun <= tcfg_q.oscSelect | calCfg_q | warmup_q |
                         (cpuClkSel_q == `GTC_SCS_SECONDARY_OSCILLATOR);
    end
  end

  // assertions
  sequence s_armed;
    spState_q == GTC_SP_ARMED && tglRise;
  endsequence
  sequence s_active_then_fall;
    spState_q == GTC_SP_ACTIVE && tglFall;
  endsequence

  chk_wrap_flag: assert property (@(posedge clk) disable iff (reset) // RL20
    wrapEvt |=> ovfFlag_q && count_q == `GTC_COUNT_RESET)
    else $error("wrap did not set overflow flag");
  chk_hold_count: assert property (@(posedge clk) disable iff (reset) // RL4
    (!countInc && !(wrEn && hitCount)) |=> $stable(count_q))
    else $error("count moved while held");
  chk_gate_off_timer: assert property (@(posedge clk) disable iff (reset) // RL23
    (!tcfg_q.timerOn && !(wrEn && hitCount)) |=> $stable(count_q))
    else $error("count moved with timer off");
  chk_free_count: assert property (@(posedge clk) disable iff (reset) // RL3
    (tcfg_q.timerOn && !gcfg_q.enable && clkTick && !(wrEn && hitCount)) |=>
      count_q == $past(count_q) + 16'h0001)
    else $error("free count missed a tick");
  chk_toggle_clear: assert property (@(posedge clk) disable iff (reset) // RL11
    !gcfg_q.toggleEn |=> !toggle_q)
    else $error("toggle flop not clear");
  chk_sp_start: assert property (@(posedge clk) disable iff (reset) // RL14
    s_armed ##0 goDone_q |=> spState_q == GTC_SP_ACTIVE)
    else $error("armed pulse did not start");
  chk_sp_done: assert property (@(posedge clk) disable iff (reset) // RL14
    s_active_then_fall ##0 !goSet |=> !goDone_q ##1 spState_q != GTC_SP_ACTIVE)
    else $error("go not cleared at trailing edge");
  chk_sp_block: assert property (@(posedge clk) disable iff (reset) // RL15
    (gcfg_q.singlePulseEn && spState_q != GTC_SP_ACTIVE) |-> !gateFinal)
    else $error("gate passed outside pulse");
  chk_spm_clear: assert property (@(posedge clk) disable iff (reset) // RL16
    (!gcfg_q.singlePulseEn && !goSet) |=> !goDone_q)
    else $error("go survived spm clear");
  chk_gate_event: assert property (@(posedge clk) disable iff (reset) // RL19
    $fell(gateVal_q) |-> gevFlag_q)
    else $error("gate fall did not set flag");
  chk_irq_mask: assert property (@(posedge clk) disable iff (reset) // RL21
    (ovfFlag_q && ovfIen_q) |=> overflowIrq)
    else $error("overflow request missing");
  chk_osc_request: assert property (@(posedge clk) disable iff (reset) // RL1
    (warmup_q || tcfg_q.oscSelect) |=> secondaryOscRun)
    else $error("oscillator not requested");
  chk_match_width: assert property (@(posedge clk) disable iff (reset) // RL7
    $rose(matchPulse_q) && !companionRollover |-> matchPulse_q [*4] ##1 !matchPulse_q)
    else $error("match pulse width wrong");
endmodule

// >>> testbench/gtc_far_side.sv
// far side model: gate pin, comparators, companion timer and count clocks
`timescale 1ns/1ps
module gtc_far_side (
  input  wire logic       clk,
  input  wire logic [2:0] lvl,
  output logic            gatePin,
  output logic            cmpOneOut,
  output logic            cmpTwoOut,
  output logic            rollover,
  output logic            oscClk,
  output logic            extClk
);
  initial begin
    gatePin   = 1'b0;
    cmpOneOut = 1'b0;
    cmpTwoOut = 1'b0;
    rollover  = 1'b0;
    oscClk    = 1'b0;
    extClk    = 1'b0;
  end
  always @(posedge clk) begin
    gatePin   <= lvl[0];
    cmpOneOut <= lvl[1];
    cmpTwoOut <= lvl[2];
  end
  // companion wraps to zero: one clock wide pulse
  task automatic roll();
    @(posedge clk);
    rollover <= 1'b1;
    @(posedge clk);
    rollover <= 1'b0;
  endtask
  // bursts of n rising edges; clock stands still between bursts
  task automatic burst(input int n, input logic ext);
    repeat (2 * n) begin
      repeat (4) @(posedge clk);
      if (ext) begin
        extClk <= ~extClk;
      end else begin
        oscClk <= ~oscClk;
      end
    end
  endtask
endmodule

// >>> testbench/gtc_timer_tb.sv
// self-checking bench of the gated timer
`timescale 1ns/1ps
`include "gtc_regs.svh"
module gtc_timer_tb;
  import gtc_pkg::*;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [2:0]  lvl;
  logic        gatePin, cmpOne, cmpTwo, rollover, oscClk, extClk;
  logic        oscRun, ovfIrq, gateIrq;
  int          badCount = 0;
  int          testsRun = 0;
  int          cycles   = 0;
  localparam logic [11:0] OFFS[6] = '{`GTC_OFF_CTRL, `GTC_OFF_GATE, `GTC_OFF_COUNT,
                                      `GTC_OFF_OSC, `GTC_OFF_FLAG, `GTC_OFF_IEN};
  localparam logic [11:0] REQA[4] = '{`GTC_OFF_CTRL, `GTC_OFF_OSC, `GTC_OFF_OSC, `GTC_OFF_OSC};
  localparam logic [31:0] REQD[4] = '{32'h8, 32'h1, 32'h2, 32'h4};

  gtc_timer #(.TIMER_ID(3), .ADDR_WIDTH(12)) uut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .secondaryOscClk(oscClk), .extClkPin(extClk), .gatePin(gatePin),
    .companionRollover(rollover), .comparatorOneOut(cmpOne), .comparatorTwoOut(cmpTwo),
    .secondaryOscRun(oscRun), .overflowIrq(ovfIrq), .gateEventIrq(gateIrq));

  gtc_far_side far (
    .clk(clk), .lvl(lvl), .gatePin(gatePin), .cmpOneOut(cmpOne), .cmpTwoOut(cmpTwo),
    .rollover(rollover), .oscClk(oscClk), .extClk(extClk));

  always #2.5 clk = ~clk;

  task conclude();
    if (badCount == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, well above the thousand-odd cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      $display("BAD %0t run too long", $time);
      conclude();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rdat, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    chk(pready, 1, "no answer");
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  task rdCnt(output logic [15:0] c);
    logic [31:0] d;
    rd(`GTC_OFF_COUNT, d);
    c = d[15:0];
  endtask

  task measure(output logic moved);
    logic [15:0] a, b;
    rdCnt(a);
    repeat (8) @(posedge clk);
    rdCnt(b);
    moved = (a !== b);
  endtask

  task pulse(input int h);
    lvl[0] <= 1'b1;
    repeat (h) @(posedge clk);
    lvl[0] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  function automatic logic [31:0] gcfg(logic ge, logic pol, logic gtm, logic spm, logic go,
                                       logic [1:0] ss);
    return {24'h0, ge, pol, gtm, spm, go, 1'b0, ss};
  endfunction

  function automatic logic [31:0] ctl(logic osc, logic [1:0] cs, logic on);
    return {28'h0, osc, cs, on};
  endfunction

  // free run without gating, else only on the active level
  function automatic logic counts(logic ge, logic pol, logic lv);
    return !ge || (pol == lv);
  endfunction

  initial begin
    logic [31:0] d;
    logic [15:0] a, b;
    logic        m, e;
    int          h;
    clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 0; lvl = 0;
    h = $urandom(62944);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (OFFS[i]) begin
      rd(OFFS[i], d);
      chk(d & 32'hFFFF_FFFB, 0, "reset value");
    end
    apb(1'b0, 12'h020, 32'h0, d, e);
    chk(e, 1, "unmapped error");
    chk(d, 0, "unmapped data");
    for (int i = 0; i < 4; i++) begin
      wr(REQA[i], REQD[i]);
      repeat (3) @(posedge clk);
      chk(oscRun, 1, "osc request");
      wr(REQA[i], 32'h0);
      repeat (3) @(posedge clk);
      chk(oscRun, 0, "osc release");
    end
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      wr(`GTC_OFF_COUNT, {16'h0, b});
      rdCnt(a);
      chk(a, b, "count load");
    end
    wr(`GTC_OFF_IEN, 32'h3);
    wr(`GTC_OFF_COUNT, 32'hFFF0);
    wr(`GTC_OFF_CTRL, ctl(0, 2'h1, 1));
    repeat (20) @(posedge clk);
    wr(`GTC_OFF_CTRL, 32'h0);
    rdCnt(a);
    chk(a < 16'h40, 1, "wrap");
    rd(`GTC_OFF_FLAG, d);
    chk(d[1], 1, "overflow flag");
    chk(ovfIrq, 1, "overflow irq");
    wr(`GTC_OFF_FLAG, 32'h2);
    rd(`GTC_OFF_FLAG, d);
    chk(d[1], 0, "overflow clear");
    chk(ovfIrq, 0, "overflow irq off");
    wr(`GTC_OFF_CTRL, ctl(0, 2'h1, 1));
    for (int i = 0; i < 8; i++) begin
      lvl <= {2'b00, i[0]};
      wr(`GTC_OFF_GATE, gcfg(i[2], i[1], 0, 0, 0, 2'h0));
      repeat (8) @(posedge clk);
      measure(m);
      chk(m, counts(i[2], i[1], i[0]), "gate level");
    end
    for (int k = 0; k < 3; k++) begin
      for (int v = 0; v < 2; v++) begin
        lvl <= v ? (3'b001 << k) : ~(3'b001 << k);
        wr(`GTC_OFF_GATE, gcfg(1, 1, 0, 0, 0, (k == 0) ? 2'h0 : 2'(k + 1)));
        repeat (8) @(posedge clk);
        measure(m);
        chk(m, v, "gate source");
      end
    end
    lvl <= 3'b000;
    wr(`GTC_OFF_GATE, gcfg(1, 1, 0, 0, 0, 2'h1));
    repeat (8) @(posedge clk);
    rdCnt(a);
    far.roll();
    repeat (12) @(posedge clk);
    rdCnt(b);
    b = b - a;
    chk(b, `GTC_INSTR_CYCLES, "match pulse");
    wr(`GTC_OFF_GATE, gcfg(0, 1, 0, 0, 0, 2'h0));
    wr(`GTC_OFF_FLAG, 32'h3);
    lvl <= 3'b001;
    repeat (8) @(posedge clk);
    rd(`GTC_OFF_GATE, d);
    chk(d[2], 1, "level high");
    lvl <= 3'b000;
    repeat (8) @(posedge clk);
    rd(`GTC_OFF_GATE, d);
    chk(d[2], 0, "level low");
    rd(`GTC_OFF_FLAG, d);
    chk(d[0], 1, "gate event");
    chk(gateIrq, 1, "gate irq");
    wr(`GTC_OFF_FLAG, 32'h1);
    rd(`GTC_OFF_FLAG, d);
    chk(d[0], 0, "gate event clear");
    wr(`GTC_OFF_CTRL, 32'h0);
    wr(`GTC_OFF_COUNT, 32'h0);
    wr(`GTC_OFF_GATE, gcfg(1, 1, 0, 1, 0, 2'h0));
    wr(`GTC_OFF_GATE, gcfg(1, 1, 0, 1, 1, 2'h0));
    wr(`GTC_OFF_CTRL, ctl(0, 2'h1, 1));
    h = $urandom_range(12, 4);
    pulse(h);
    rd(`GTC_OFF_GATE, d);
    chk(d[3], 0, "go cleared");
    rdCnt(a);
    chk(a + 16'h0001 >= h && a <= h, 1, "single pulse");
    pulse(h);
    rdCnt(b);
    chk(b, a, "no rearm");
    wr(`GTC_OFF_GATE, gcfg(1, 1, 0, 1, 1, 2'h0));
    wr(`GTC_OFF_GATE, gcfg(1, 1, 0, 0, 1, 2'h0));
    rd(`GTC_OFF_GATE, d);
    chk(d[3], 0, "go follows enable");
    wr(`GTC_OFF_GATE, gcfg(1, 1, 1, 0, 0, 2'h0));
    measure(m);
    chk(m, 0, "toggle start");
    pulse(4);
    measure(m);
    chk(m, 1, "toggle on");
    rd(`GTC_OFF_GATE, d);
    chk(d[2], 1, "toggle level");
    pulse(4);
    measure(m);
    chk(m, 0, "toggle off");
    wr(`GTC_OFF_GATE, gcfg(1, 1, 1, 1, 0, 2'h0));
    wr(`GTC_OFF_GATE, gcfg(1, 1, 1, 1, 1, 2'h0));
    pulse(4);
    measure(m);
    chk(m, 1, "full cycle");
    pulse(4);
    rd(`GTC_OFF_GATE, d);
    chk(d[3], 0, "full cycle done");
    pulse(4);
    measure(m);
    chk(m, 0, "one cycle only");
    wr(`GTC_OFF_GATE, 32'h0);
    wr(`GTC_OFF_CTRL, ctl(1, 2'h2, 1));
    for (int s = 0; s < 3; s++) begin
      rdCnt(a);
      h = $urandom_range(8, 1);
      far.burst(h, s != 0);
      repeat (8) @(posedge clk);
      rdCnt(b);
      b = b - a;
      chk(b, (s == 1) ? 0 : h, "clock edges");
      if (s == 1) begin
        wr(`GTC_OFF_CTRL, ctl(0, 2'h2, 1));
      end
    end
    conclude();
  end
endmodule
